// ---- decr_top.sv ----
// driver enable, reset and output gating for four low-side channels
`timescale 1ns/10ps
`include "decr_defs.svh"
module decr_top (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // enable pin, pulled low when floating
    input  wire logic             drive_enable_n,
    // serial side, synchronous strobes
    input  wire logic             shift_clk,
    input  wire logic             serial_in,
    input  wire logic             update_strobe,
    // protection inputs
    input  wire logic             thermal_shutdown,
    input  wire decr_pkg::decr_ch_t ocp_event,
    input  wire decr_pkg::decr_ch_t ocp_retry,
    // outputs
    output logic                  serial_out,
    output decr_pkg::decr_ch_t    gate,
    output decr_pkg::decr_ch_t    fault_bits,
    output logic                  fault_flag_n
);
    decr_pkg::decr_state_t state_q = decr_pkg::DECR_POR;
    decr_pkg::decr_state_t state_d;
    logic [2:0]            por_cnt_q = 3'h0;
    logic [2:0]            por_cnt_d;
    decr_pkg::decr_ch_t    hold_q;
    decr_pkg::decr_ch_t    hold_d;
    decr_pkg::decr_ch_t    outreg_q;
    decr_pkg::decr_ch_t    outreg_d;
    logic                  sclk_q;
    logic                  upd_q;
    logic                  serial_out_q;
    logic                  sclk_rise;
    logic                  upd_rise;
    logic                  int_rst;
    logic                  por_done;
    decr_pkg::decr_ch_t    fault_w;
    decr_pkg::decr_ch_t    gate_d;
    logic                  fault_n_d;

    // power-up reset from declared start values
    assign por_done = (por_cnt_q == 3'(`DECR_PORST_CYCLES - 1));
    assign int_rst  = rst | (state_q == decr_pkg::DECR_POR);
    always_comb begin
        state_d   = state_q;
        por_cnt_d = por_cnt_q;
        unique case (state_q)
            decr_pkg::DECR_POR: begin
                por_cnt_d = por_cnt_q + 3'h1;
                if (por_done) begin
                    state_d = decr_pkg::DECR_RUN;
                end
            end
            decr_pkg::DECR_RUN: begin
                por_cnt_d = por_cnt_q;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        state_q   <= state_d;
        por_cnt_q <= por_cnt_d;
    end

    // serial registers, independent of drive enable
    assign sclk_rise = shift_clk & ~sclk_q;
    assign upd_rise  = update_strobe & ~upd_q;
    assign hold_d    = sclk_rise ? {hold_q[2:0], serial_in} : hold_q;
    assign outreg_d  = upd_rise ? hold_q : outreg_q;
    always_ff @(posedge clk) begin
        if (int_rst) begin
            hold_q       <= `DECR_REG_RST_VAL;
            outreg_q     <= `DECR_REG_RST_VAL;
            sclk_q       <= 1'b0;
            upd_q        <= 1'b0;
            serial_out_q <= 1'b0;
        end else begin
            hold_q       <= hold_d;
            outreg_q     <= outreg_d;
            sclk_q       <= shift_clk;
            upd_q        <= update_strobe;
            serial_out_q <= hold_d[3];
        end
    end

    // per-channel fault latches
    genvar i;
    generate
        for (i = 0; i < `DECR_NUM_CH; i++) begin : g_ch
            decr_chan_if cif ();
            assign cif.out_bit   = outreg_q[i];
            assign cif.ocp_event = ocp_event[i];
            assign cif.ocp_retry = ocp_retry[i];
            assign cif.clr       = int_rst;
            assign fault_w[i]    = cif.fault;
            decr_fault_ch u_ch (
                .clk (clk),
                .rst (int_rst),
                .ch  (cif.chan)
            );
        end
    endgenerate

    // output gating
    assign gate_d = outreg_q & {4{~drive_enable_n}} & ~fault_w
                    & {4{~thermal_shutdown}};
    assign fault_n_d = ~(|fault_w | thermal_shutdown);
    always_ff @(posedge clk) begin
        if (int_rst) begin
            gate         <= 4'h0;
            fault_bits   <= 4'h0;
            fault_flag_n <= 1'b1;
        end else begin
            gate         <= gate_d;
            fault_bits   <= fault_w;
            fault_flag_n <= fault_n_d;
        end
    end
    assign serial_out = serial_out_q;

    // assertion sequences
    sequence s_gate_off;
        gate == 4'h0;
    endsequence
    sequence s_gate_follows;
        gate == ($past(outreg_q) & ~$past(fault_w));
    endsequence
    sequence s_shift_step;
        hold_q == {$past(hold_q[2:0]), $past(serial_in)};
    endsequence
    sequence s_tsd_exit;
        thermal_shutdown ##1 !thermal_shutdown;
    endsequence
    sequence s_regs_clear;
        (hold_q == 4'h0) && (outreg_q == 4'h0);
    endsequence

    // assertion properties
    property p_enable_off;
        @(posedge clk) disable iff (int_rst)
            drive_enable_n |=> s_gate_off;
    endproperty
    property p_tsd_off;
        @(posedge clk) disable iff (int_rst)
            thermal_shutdown |=> s_gate_off;
    endproperty
    property p_gate_and;
        @(posedge clk) disable iff (int_rst)
            !drive_enable_n && !thermal_shutdown |=> s_gate_follows;
    endproperty
    property p_shift;
        @(posedge clk) disable iff (int_rst)
            sclk_rise |=> s_shift_step;
    endproperty
    property p_update;
        @(posedge clk) disable iff (int_rst)
            upd_rise |=> (outreg_q == $past(hold_q));
    endproperty
    property p_rst_regs;
        @(posedge clk)
            rst |=> s_regs_clear;
    endproperty
    property p_rst_fault;
        @(posedge clk)
            rst |=> (fault_w == 4'h0);
    endproperty
    property p_resume;
        @(posedge clk) disable iff (int_rst)
            s_tsd_exit ##0 !drive_enable_n |=> s_gate_follows;
    endproperty
    property p_por_hold;
        @(posedge clk)
            (state_q == decr_pkg::DECR_POR) |=> s_regs_clear ##0 s_gate_off;
    endproperty
    property p_por_end;
        @(posedge clk)
            (state_q == decr_pkg::DECR_POR) && por_done |=> (state_q == decr_pkg::DECR_RUN);
    endproperty
    property p_serout;
        @(posedge clk) disable iff (int_rst)
            serial_out == hold_q[3];
    endproperty
    property p_hold_still;
        @(posedge clk) disable iff (int_rst)
            !sclk_rise |=> $stable(hold_q);
    endproperty
    property p_out_still;
        @(posedge clk) disable iff (int_rst)
            !upd_rise |=> $stable(outreg_q);
    endproperty
    property p_flag_tsd;
        @(posedge clk) disable iff (int_rst)
            thermal_shutdown |=> !fault_flag_n;
    endproperty
    property p_fault_off;
        @(posedge clk) disable iff (int_rst)
            (fault_w != 4'h0) |=> ((gate & $past(fault_w)) == 4'h0);
    endproperty
    property p_rst_serial;
        @(posedge clk)
            rst |=> (serial_out == 1'b0);
    endproperty

    // output gating checks
    AST_ENABLE_OFF: assert property (p_enable_off)
        else $error("outputs on while enable high");
    AST_TSD_OFF: assert property (p_tsd_off)
        else $error("outputs on during thermal shutdown");
    AST_GATE_AND: assert property (p_gate_and)
        else $error("gate term mismatch");
    AST_FAULT_OFF: assert property (p_fault_off)
        else $error("faulted channel still driven");
    AST_REENABLE: assert property (p_resume)
        else $error("no resume after shutdown");
    AST_FLAG_TSD: assert property (p_flag_tsd)
        else $error("fault flag high during thermal shutdown");

    // serial register checks
    AST_SHIFT_ENA: assert property (p_shift)
        else $error("shift lost");
    AST_HOLD_STILL: assert property (p_hold_still)
        else $error("holding register moved without shift");
    AST_SEROUT: assert property (p_serout)
        else $error("serial out not last holding bit");
    AST_UPDATE: assert property (p_update)
        else $error("update did not copy");
    AST_OUT_STILL: assert property (p_out_still)
        else $error("output register moved without update");

    // reset checks
    AST_RST_REGS: assert property (p_rst_regs)
        else $error("reset left registers set");
    AST_RST_FAULT: assert property (p_rst_fault)
        else $error("reset left fault set");
    AST_RST_SERIAL: assert property (p_rst_serial)
        else $error("reset left serial out set");
    AST_POR_HOLD: assert property (p_por_hold)
        else $error("power-up reset did not clear state");
    AST_POR_END: assert property (p_por_end)
        else $error("power-up reset did not end");
endmodule // decr_top

// ---- decr_defs.svh ----
// constants for the driver enable and reset control block
`ifndef DECR_DEFS_SVH
`define DECR_DEFS_SVH
`define DECR_NUM_CH        4
`define DECR_REG_RST_VAL   4'h0
`define DECR_CLK_MHZ       20
`define DECR_PORST_CYCLES  4
`define DECR_SCLK_WAIT_CYCLES 400
`endif

// ---- decr_pkg.sv ----
// types for the driver enable and reset control block
package decr_pkg;
    typedef logic [3:0] decr_ch_t;
    typedef enum logic [0:0] {DECR_POR, DECR_RUN} decr_state_t;
endpackage

// ---- decr_chan_if.sv ----
// interface carrying per-channel serial and fault signals
`timescale 1ns/10ps
interface decr_chan_if;
    logic out_bit;
    logic ocp_event;
    logic ocp_retry;
    logic clr;
    logic fault;
    modport ctrl (output out_bit, output ocp_event, output ocp_retry, output clr, input fault);
    modport chan (input out_bit, input ocp_event, input ocp_retry, input clr, output fault);
endinterface

// ---- decr_fault_ch.sv ----
// one channel overcurrent fault latch
`timescale 1ns/10ps
`include "decr_defs.svh"
module decr_fault_ch (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // channel link
    decr_chan_if.chan ch
);
    logic overcurrent_fault_latch_q;
    logic overcurrent_fault_latch_d;
    logic set_w;
    logic clr_w;

    assign set_w = ch.ocp_event & ch.out_bit;
    assign clr_w = ch.clr | ch.ocp_retry | ~ch.out_bit;
    // set wins over clear except under reset
    assign overcurrent_fault_latch_d = set_w ? 1'b1 : (clr_w ? 1'b0 : overcurrent_fault_latch_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            overcurrent_fault_latch_q <= 1'b0;
        end else begin
            overcurrent_fault_latch_q <= overcurrent_fault_latch_d;
        end
    end
    assign ch.fault = overcurrent_fault_latch_q;

    AST_RST_CLR: assert property (@(posedge clk) rst |=> !overcurrent_fault_latch_q)
        else $error("fault latch not cleared by reset");
endmodule // decr_fault_ch

// ---- decr_ctrl_model.sv ----
// controller model driving the serial pins
`timescale 1ns/10ps
`include "decr_defs.svh"
module decr_ctrl_model (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      shift_clk,
    output logic      serial_in,
    output logic      update_strobe
);
    initial begin
        shift_clk     = 1'b0;
        serial_in     = 1'b0;
        update_strobe = 1'b0;
    end
    // msb first, so bit i lands on channel i
    task automatic send(input logic [3:0] w);
        repeat (`DECR_SCLK_WAIT_CYCLES) @(negedge clk);
        for (int i = 3; i >= 0; i--) begin
            serial_in <= w[i];
            shift_clk <= 1'b1;
            @(negedge clk);
            shift_clk <= 1'b0;
            serial_in <= ~w[i];
            @(negedge clk);
        end
        update_strobe <= 1'b1;
        @(negedge clk);
        update_strobe <= 1'b0;
        @(negedge clk);
    endtask
endmodule // decr_ctrl_model

// ---- decr_top_tb.sv ----
// testbench for the driver enable and reset control block
`timescale 1ns/10ps
module decr_top_tb;
    logic               clk;
    logic               rst;
    logic               drive_enable_n;
    logic               thermal_shutdown;
    decr_pkg::decr_ch_t ocp_event;
    decr_pkg::decr_ch_t ocp_retry;
    logic               shift_clk;
    logic               serial_in;
    logic               update_strobe;
    logic               serial_out;
    decr_pkg::decr_ch_t gate;
    decr_pkg::decr_ch_t fault_bits;
    logic               fault_flag_n;
    int                 err_count = 0;
    int                 checks = 0;

    decr_ctrl_model ctl (.clk(clk), .shift_clk(shift_clk), .serial_in(serial_in),
        .update_strobe(update_strobe));
    decr_top dut (.clk(clk), .rst(rst), .drive_enable_n(drive_enable_n),
        .shift_clk(shift_clk), .serial_in(serial_in), .update_strobe(update_strobe),
        .thermal_shutdown(thermal_shutdown), .ocp_event(ocp_event), .ocp_retry(ocp_retry),
        .serial_out(serial_out), .gate(gate), .fault_bits(fault_bits),
        .fault_flag_n(fault_flag_n));

    task automatic wrap_up;
        if (err_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input decr_pkg::decr_ch_t exp, input decr_pkg::decr_ch_t act);
        checks++;
        if (act !== exp) begin
            err_count++;
            $display("ERROR %0t exp %h got %h", $time, exp, act);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_power_up;
        rst              = 1'b1;
        drive_enable_n   = 1'b0;
        thermal_shutdown = 1'b0;
        ocp_event        = 4'h0;
        ocp_retry        = 4'h0;
        idle(16);
        rst = 1'b0;
        idle(1);
        chk(4'h0, gate);
        chk(4'h1, {3'h0, fault_flag_n});
        chk(4'h0, fault_bits);
        chk(4'h0, {3'h0, serial_out});
    endtask
    task automatic t_update;
        ctl.send(4'hA);
        idle(3);
        chk(4'hA, gate);
        chk(4'h1, {3'h0, serial_out});
    endtask
    task automatic t_enable;
        drive_enable_n = 1'b1;
        idle(2);
        chk(4'h0, gate);
        ctl.send(4'h5);
        idle(3);
        chk(4'h0, gate);
        chk(4'h0, {3'h0, serial_out});
        drive_enable_n = 1'b0;
        idle(2);
        chk(4'h5, gate);
    endtask
    task automatic t_thermal;
        thermal_shutdown = 1'b1;
        idle(2);
        chk(4'h0, gate);
        chk(4'h0, {3'h0, fault_flag_n});
        thermal_shutdown = 1'b0;
        idle(2);
        chk(4'h5, gate);
        chk(4'h1, {3'h0, fault_flag_n});
    endtask
    task automatic t_fault_reset;
        ocp_event = 4'h1;
        idle(1);
        ocp_event = 4'h0;
        idle(2);
        chk(4'h4, gate);
        chk(4'h1, fault_bits);
        chk(4'h0, {3'h0, fault_flag_n});
        ocp_retry = 4'h1;
        idle(1);
        ocp_retry = 4'h0;
        idle(2);
        chk(4'h5, gate);
        ocp_event = 4'h4;
        idle(1);
        ocp_event = 4'h0;
        idle(2);
        chk(4'h4, fault_bits);
        chk(4'h1, gate);
        rst = 1'b1;
        idle(1);
        rst = 1'b0;
        idle(2);
        chk(4'h0, fault_bits);
        chk(4'h0, gate);
        chk(4'h1, {3'h0, fault_flag_n});
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1_000_000;
        err_count++;
        wrap_up();
    end
    initial begin
        t_power_up();
        t_update();
        t_enable();
        t_thermal();
        t_fault_reset();
        wrap_up();
    end
endmodule // decr_top_tb
